// *** common/burst4_sram_pkg.sv ***
// shared constants and types for the burst-of-four sram link
// assumes both ends run on the same core_clk and reset
package burst4_sram_pkg;
    // organisation
    localparam int LANE_BITS = 9;              // data bits gated by one byte-write lane
    localparam int BEATS = 4;                  // fixed burst length
    localparam int DEF_DATA_W = 36;            // 36-bit organisation; 18 is the other
    localparam int DEF_ADDR_W = 8;             // plain default, real parts are far deeper
    // timing counts in core_clk edges after the command edge t
    localparam int FIRST_PAIR_LAT = 2;         // beats 0/1 at t+2.0 / t+2.5
    localparam int SECOND_PAIR_LAT = 3;        // beats 2/3 at t+3.0 / t+3.5
    localparam int DRAIN_EDGES = 5;            // edges until a burst, read data included, is gone
    // reset values of link pins
    localparam logic SEL_IDLE = 1'b1;          // selects are active low
    localparam logic LANE_IDLE = 1'b1;         // lane high means no byte written
    // controller clock-stop states, gray along run -> drain -> stopped
    typedef enum logic [1:0]
    {
        ST_RUN = 2'h0,
        ST_DRAIN = 2'h1,
        ST_STOPPED = 2'h3
    } stop_state_t;
endpackage

// *** common/burst4_link_if.sv ***
// link between the memory controller and the burst-of-four sram
// assumes one clock; each cycle carries a true-edge and a complementary-edge half
`timescale 1ns/1ns
interface burst4_link_if #(
    parameter int ADDR_W = burst4_sram_pkg::DEF_ADDR_W,
    parameter int DATA_W = burst4_sram_pkg::DEF_DATA_W
);
    localparam int LANES = DATA_W / burst4_sram_pkg::LANE_BITS;
    // command, sampled on the true edge
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] addr;
    // write beats: rise half is the true-edge beat, fall half the complementary one
    logic [DATA_W-1:0] wd_rise;
    logic [DATA_W-1:0] wd_fall;
    // bit n of each lane vector is byte_laneN_write_n for that half
    logic [LANES-1:0] lane_rise_n;
    logic [LANES-1:0] lane_fall_n;
    // read return, one pair of beats per cycle
    logic rq_valid;
    logic [DATA_W-1:0] rq_rise;
    logic [DATA_W-1:0] rq_fall;

    modport ctrl
    (
        output rd_sel_n, wr_sel_n, addr, wd_rise, wd_fall, lane_rise_n, lane_fall_n,
        input rq_valid, rq_rise, rq_fall
    );
    modport mem
    (
        input rd_sel_n, wr_sel_n, addr, wd_rise, wd_fall, lane_rise_n, lane_fall_n,
        output rq_valid, rq_rise, rq_fall
    );
endinterface

// *** design/burst4_sram_device.sv ***
// memory end of the burst-of-four link: command acceptance, burst sequencing, byte-lane writes
// assumes the controller drives the link from flops on the same core_clk
//
// Function
// - read select low at edge starts read
// - write select low at edge starts write
// - controller drains all bursts before clock stop
// - controller spaces same-kind commands two edges apart
// - back-to-back same-kind command: later one discarded
// - both selects after idle cycle: read wins
// - write beats taken at t+2.0 through t+3.5
// - 18-bit: two lanes gate bytes, both high aborts
// - 36-bit: four lanes gate bytes, all high aborts
// - burst addresses start, +1, +2, +3
// - read and write sequencing run independently
`timescale 1ns/1ns
module burst4_sram_device #(
    parameter int ADDR_W = burst4_sram_pkg::DEF_ADDR_W,
    parameter int DATA_W = burst4_sram_pkg::DEF_DATA_W
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link to the controller
    burst4_link_if.mem link,
    // status pulses
    output logic rd_accepted,
    output logic wr_accepted,
    output logic rd_discarded,
    output logic wr_discarded,
    output logic beat_aborted,
    // levels
    output logic idle_cycle,
    output logic busy
);
    localparam int LANES = DATA_W / burst4_sram_pkg::LANE_BITS;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int LB = burst4_sram_pkg::LANE_BITS;

    // command history, one edge deep
    logic rd_last;
    logic wr_last;
    logic idle_last;
    logic next_rd_last;
    logic next_wr_last;
    logic next_idle_last;

    // burst pipelines: stage 0 set at edge t, stage 1 drives t+2, stage 2 drives t+3
    logic [2:0] rd_v;
    logic [2:0] wr_v;
    logic [ADDR_W-1:0] rd_a [3];
    logic [ADDR_W-1:0] wr_a [3];
    logic [2:0] next_rd_v;
    logic [2:0] next_wr_v;
    logic [ADDR_W-1:0] next_rd_a [3];
    logic [ADDR_W-1:0] next_wr_a [3];

    // read return and status registers
    logic rq_valid;
    logic [DATA_W-1:0] rq_rise;
    logic [DATA_W-1:0] rq_fall;
    logic next_rq_valid;
    logic [DATA_W-1:0] next_rq_rise;
    logic [DATA_W-1:0] next_rq_fall;
    logic next_rd_accepted;
    logic next_wr_accepted;
    logic next_rd_discarded;
    logic next_wr_discarded;
    logic next_beat_aborted;

    // decisions of this edge
    logic rd_go;
    logic wr_go;
    logic rd_act;
    logic wr_act;
    logic [ADDR_W-1:0] rd_base;
    logic [ADDR_W-1:0] wr_base;
    logic [ADDR_W-1:0] rd_next_addr;
    logic [ADDR_W-1:0] wr_next_addr;
    wire [DATA_W-1:0] mem_rise;
    wire [DATA_W-1:0] mem_fall;

    // address n words on, for the second beat of a pair or the base of the second pair, wrapping in the array
    function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input int n);
        step_addr = a + ADDR_W'(n);
    endfunction

    // command acceptance
    always_comb
    begin
        rd_go = !link.rd_sel_n && !rd_last;
        // a read after an idle edge takes precedence over a write on the same edge
        wr_go = !link.wr_sel_n && !wr_last && !(rd_go && idle_last);
        next_rd_last = rd_go;
        next_wr_last = wr_go;
        // only accepted commands count as read and write history, so a third in a row is taken again
        next_idle_last = link.rd_sel_n && link.wr_sel_n;
        next_rd_accepted = rd_go;
        next_wr_accepted = wr_go;
        next_rd_discarded = !link.rd_sel_n && !rd_go;
        next_wr_discarded = !link.wr_sel_n && !wr_go;
    end

    // burst sequencing; read and write pipelines never look at each other
    always_comb
    begin
        next_rd_v = {rd_v[1:0], rd_go};
        next_wr_v = {wr_v[1:0], wr_go};
        next_rd_a[0] = link.addr;
        next_wr_a[0] = link.addr;
        for (int i = 1; i < 3; i++)
        begin
            next_rd_a[i] = rd_a[i-1];
            next_wr_a[i] = wr_a[i-1];
        end
        // stage 1 and stage 2 are exclusive because of the two-edge spacing
        rd_act = rd_v[1] || rd_v[2];
        wr_act = wr_v[1] || wr_v[2];
        rd_base = rd_v[1] ? rd_a[1] : step_addr(rd_a[2], 2);
        wr_base = wr_v[1] ? wr_a[1] : step_addr(wr_a[2], 2);
        rd_next_addr = step_addr(rd_base, 1);
        wr_next_addr = step_addr(wr_base, 1);
    end

    // read return and abort detection
    always_comb
    begin
        next_rq_valid = rd_act;
        next_rq_rise = rd_act ? mem_rise : '0;
        next_rq_fall = rd_act ? mem_fall : '0;
        // a beat with every lane high writes nothing and is flagged
        next_beat_aborted = wr_act && ((&link.lane_rise_n) || (&link.lane_fall_n));
    end

    // register all next values
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_last <= 1'b0;
            wr_last <= 1'b0;
            idle_last <= 1'b1;
            rd_v <= '0;
            wr_v <= '0;
            for (int i = 0; i < 3; i++)
            begin
                rd_a[i] <= '0;
                wr_a[i] <= '0;
            end
            rq_valid <= 1'b0;
            rq_rise <= '0;
            rq_fall <= '0;
            rd_accepted <= 1'b0;
            wr_accepted <= 1'b0;
            rd_discarded <= 1'b0;
            wr_discarded <= 1'b0;
            beat_aborted <= 1'b0;
        end
        else
        begin
            rd_last <= next_rd_last;
            wr_last <= next_wr_last;
            idle_last <= next_idle_last;
            rd_v <= next_rd_v;
            wr_v <= next_wr_v;
            rd_a <= next_rd_a;
            wr_a <= next_wr_a;
            rq_valid <= next_rq_valid;
            rq_rise <= next_rq_rise;
            rq_fall <= next_rq_fall;
            rd_accepted <= next_rd_accepted;
            wr_accepted <= next_wr_accepted;
            rd_discarded <= next_rd_discarded;
            wr_discarded <= next_wr_discarded;
            beat_aborted <= next_beat_aborted;
        end
    end

    // one array per byte lane so each lane is written on its own
    genvar l;
    generate
        for (l = 0; l < LANES; l++)
        begin : g_lane
            logic [LB-1:0] store [DEPTH];
            // both halves of a pair land in the same edge; addresses differ by one
            always_ff @(posedge core_clk)
            begin
                if (wr_act && !link.lane_rise_n[l])
                begin
                    store[wr_base] <= link.wd_rise[l*LB +: LB];
                end
                if (wr_act && !link.lane_fall_n[l])
                begin
                    store[wr_next_addr] <= link.wd_fall[l*LB +: LB];
                end
            end
            // old contents are read when a write hits the same word on the same edge
            assign mem_rise[l*LB +: LB] = store[rd_base];
            assign mem_fall[l*LB +: LB] = store[rd_next_addr];
        end
    endgenerate

    // link outputs and levels
    assign link.rq_valid = rq_valid;
    assign link.rq_rise = rq_rise;
    assign link.rq_fall = rq_fall;
    assign idle_cycle = idle_last;
    // busy covers the burst pipelines and read return but not command history, so a clock stop while high loses a burst
    assign busy = (|rd_v) || (|wr_v) || rq_valid;
endmodule

// *** design/burst4_sram_controller.sv ***
// controller end of the burst-of-four link: command spacing, write beat timing, clock-stop drain
// assumes the device samples the link on the same core_clk
`timescale 1ns/1ns
module burst4_sram_controller #(
    parameter int ADDR_W = burst4_sram_pkg::DEF_ADDR_W,
    parameter int DATA_W = burst4_sram_pkg::DEF_DATA_W
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link to the memory
    burst4_link_if.ctrl link,
    // read requests
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ready,
    // write requests: beat b in bits b*DATA_W, lanes of beat b in bits b*LANES
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [4*DATA_W-1:0] wr_data,
    input wire logic [4*(DATA_W/9)-1:0] wr_lanes_n,
    output logic wr_ready,
    // read data, beats {fall, rise}
    output logic rd_valid,
    output logic [2*DATA_W-1:0] rd_data,
    // clock stop
    input wire logic stop_req,
    output logic stop_ok
);
    localparam int LANES = DATA_W / burst4_sram_pkg::LANE_BITS;
    localparam int DW = 4 * DATA_W;
    localparam int LW = 4 * LANES;
    localparam int DR = burst4_sram_pkg::DRAIN_EDGES;

    burst4_sram_pkg::stop_state_t state;
    burst4_sram_pkg::stop_state_t next_state;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [2:0] hv;
    logic [DW-1:0] hd [3];
    logic [LW-1:0] hl [3];
    logic [DATA_W-1:0] wd_rise;
    logic [DATA_W-1:0] wd_fall;
    logic [LANES-1:0] ln_rise;
    logic [LANES-1:0] ln_fall;
    logic [DR-1:0] hist;
    logic next_rd_sel_n;
    logic next_wr_sel_n;
    logic [ADDR_W-1:0] next_addr;
    logic [2:0] next_hv;
    logic [DW-1:0] next_hd [3];
    logic [LW-1:0] next_hl [3];
    logic [DATA_W-1:0] next_wd_rise;
    logic [DATA_W-1:0] next_wd_fall;
    logic [LANES-1:0] next_ln_rise;
    logic [LANES-1:0] next_ln_fall;
    logic [DR-1:0] next_hist;
    logic next_rd_valid;
    logic [2*DATA_W-1:0] next_rd_data;
    logic accepting;
    logic rd_go;
    logic wr_go;

    // one command per edge, and never the same kind on two edges in a row
    always_comb
    begin
        accepting = (state == burst4_sram_pkg::ST_RUN) && !stop_req;
        rd_ready = accepting && rd_sel_n;
        rd_go = rd_req && rd_ready;
        // a write never shares an edge with a read, so the idle-edge drop cannot bite
        wr_ready = accepting && wr_sel_n && !rd_go;
        wr_go = wr_req && wr_ready;
        next_rd_sel_n = !rd_go;
        next_wr_sel_n = !wr_go;
        next_addr = rd_go ? rd_addr : (wr_go ? wr_addr : addr);
    end

    // write beats: held at accept, driven two and three edges after the command edge
    always_comb
    begin
        next_hv = {hv[1:0], wr_go};
        next_hd[0] = wr_data;
        next_hl[0] = wr_lanes_n;
        for (int i = 1; i < 3; i++)
        begin
            next_hd[i] = hd[i-1];
            next_hl[i] = hl[i-1];
        end
        // idle beats keep every lane high so stray data is never written
        next_wd_rise = '0;
        next_wd_fall = '0;
        next_ln_rise = '1;
        next_ln_fall = '1;
        if (hv[1])
        begin
            next_wd_rise = hd[1][0 +: DATA_W];
            next_wd_fall = hd[1][DATA_W +: DATA_W];
            next_ln_rise = hl[1][0 +: LANES];
            next_ln_fall = hl[1][LANES +: LANES];
        end
        else if (hv[2])
        begin
            next_wd_rise = hd[2][2*DATA_W +: DATA_W];
            next_wd_fall = hd[2][3*DATA_W +: DATA_W];
            next_ln_rise = hl[2][2*LANES +: LANES];
            next_ln_fall = hl[2][3*LANES +: LANES];
        end
        next_rd_valid = link.rq_valid;
        next_rd_data = {link.rq_fall, link.rq_rise};
    end

    // clock-stop drain: wait until no command is in flight anywhere
    always_comb
    begin
        next_hist = {hist[DR-2:0], rd_go || wr_go};
        next_state = state;
        case (state)
            burst4_sram_pkg::ST_RUN:
                if (stop_req)
                    next_state = burst4_sram_pkg::ST_DRAIN;
            burst4_sram_pkg::ST_DRAIN:
                if (hist == '0 && rd_sel_n && wr_sel_n)
                    next_state = burst4_sram_pkg::ST_STOPPED;
            burst4_sram_pkg::ST_STOPPED:
                if (!stop_req)
                    next_state = burst4_sram_pkg::ST_RUN;
            default:
                next_state = burst4_sram_pkg::ST_RUN;
        endcase
    end

    // register all next values
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= burst4_sram_pkg::ST_RUN;
            rd_sel_n <= burst4_sram_pkg::SEL_IDLE;
            wr_sel_n <= burst4_sram_pkg::SEL_IDLE;
            addr <= '0;
            hv <= '0;
            for (int i = 0; i < 3; i++)
            begin
                hd[i] <= '0;
                hl[i] <= '1;
            end
            wd_rise <= '0;
            wd_fall <= '0;
            ln_rise <= '1;
            ln_fall <= '1;
            hist <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end
        else
        begin
            state <= next_state;
            rd_sel_n <= next_rd_sel_n;
            wr_sel_n <= next_wr_sel_n;
            addr <= next_addr;
            hv <= next_hv;
            hd <= next_hd;
            hl <= next_hl;
            wd_rise <= next_wd_rise;
            wd_fall <= next_wd_fall;
            ln_rise <= next_ln_rise;
            ln_fall <= next_ln_fall;
            hist <= next_hist;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    assign link.rd_sel_n = rd_sel_n;
    assign link.wr_sel_n = wr_sel_n;
    assign link.addr = addr;
    assign link.wd_rise = wd_rise;
    assign link.wd_fall = wd_fall;
    assign link.lane_rise_n = ln_rise;
    assign link.lane_fall_n = ln_fall;
    assign stop_ok = (state == burst4_sram_pkg::ST_STOPPED);
endmodule

// *** tb/burst4_sram_props.sv ***
// assertions on the link that joins the controller and the device
// assumes one clock domain; the bench instantiates it beside that link
`timescale 1ns/1ns
module burst4_sram_props #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 36
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // command side of the link
    input wire logic rd_sel_n,
    input wire logic wr_sel_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wd_rise,
    input wire logic [DATA_W-1:0] wd_fall,
    input wire logic [DATA_W/9-1:0] lane_rise_n,
    input wire logic [DATA_W/9-1:0] lane_fall_n,
    // read return
    input wire logic rq_valid,
    input wire logic [DATA_W-1:0] rq_rise,
    input wire logic [DATA_W-1:0] rq_fall
);
    // all lanes high means no byte is written in either half
    wire lanes_idle = &lane_rise_n && &lane_fall_n;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // same-kind commands stay two edges apart
    a_read_spacing: assert property (!rd_sel_n |=> rd_sel_n)
        else $error("read selects on adjacent edges");
    a_write_spacing: assert property (!wr_sel_n |=> wr_sel_n)
        else $error("write selects on adjacent edges");
    // a read returns two pairs, three and four edges later
    a_read_answer: assert property (!rd_sel_n |-> ##3 rq_valid ##1 rq_valid)
        else $error("read pairs missing");
    a_read_cause: assert property (rq_valid |-> !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4))
        else $error("read pair without a read");
    a_read_idle_zero: assert property (!rq_valid |-> rq_rise == '0 && rq_fall == '0)
        else $error("read data not cleared");
    // lanes only open two and three edges after a write
    a_lane_cause: assert property (!lanes_idle |-> !$past(wr_sel_n, 2) || !$past(wr_sel_n, 3))
        else $error("lanes open without a write");
    a_lane_release: assert property (!wr_sel_n ##2 wr_sel_n |-> ##2 lanes_idle)
        else $error("lanes still open after burst");
    // a write right after a read must not stall the read
    a_rw_overlap: assert property (!rd_sel_n ##1 !wr_sel_n |-> ##2 rq_valid ##1 rq_valid)
        else $error("read held up by write");
    // the address only moves with a command, so a stray update cannot start a burst elsewhere
    a_addr_hold: assert property (rd_sel_n && wr_sel_n |-> $stable(addr))
        else $error("address moved without a command");
    // main scenarios
    c_read: cover property (!rd_sel_n ##3 rq_valid);
    c_write: cover property (!wr_sel_n ##2 !lanes_idle);
    c_overlap: cover property (!rd_sel_n ##1 !wr_sel_n);
endmodule

// *** tb/burst4_sram_cmd_bytewrite_tb.sv ***
// bench: controller and 36-bit device joined, plus an 18-bit device on a rule-breaking link
// assumes the package, the interface and both design modules are compiled first
`timescale 1ns/1ns
module burst4_sram_cmd_bytewrite_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic stop_req = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] wr_addr = 8'h00;
    logic [143:0] wr_data = '0;
    logic [15:0] wr_lanes_n = 16'hFFFF;
    wire rd_ready, wr_ready, rd_valid, stop_ok;
    wire [71:0] rd_data;
    // status of the joined device and of the test-link device
    wire [6:0] st;
    wire [6:0] st2;
    logic [35:0] mem [256];
    logic [17:0] mem2 [256];
    integer seed = 32'h3fe7;
    int fail_count = 0;
    int checks = 0;

    // the joined pair runs on the default organisation; only the test link is narrowed
    burst4_link_if link();
    burst4_link_if #(.DATA_W(18)) link2();
    burst4_sram_controller u_burst4_sram_controller (.core_clk(core_clk), .rst(rst),
        .link(link), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_lanes_n(wr_lanes_n), .wr_ready(wr_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .stop_req(stop_req), .stop_ok(stop_ok));
    burst4_sram_device u_burst4_sram_device (.core_clk(core_clk), .rst(rst),
        .link(link), .rd_accepted(st[0]), .wr_accepted(st[1]), .rd_discarded(st[2]), .wr_discarded(st[3]),
        .beat_aborted(st[4]), .idle_cycle(st[5]), .busy(st[6]));
    burst4_sram_device #(.DATA_W(18)) u_burst4_sram_device2 (.core_clk(core_clk), .rst(rst),
        .link(link2), .rd_accepted(st2[0]), .wr_accepted(st2[1]), .rd_discarded(st2[2]),
        .wr_discarded(st2[3]), .beat_aborted(st2[4]), .idle_cycle(st2[5]), .busy(st2[6]));
    burst4_sram_props u_burst4_sram_props (.core_clk(core_clk), .rst(rst),
        .rd_sel_n(link.rd_sel_n), .wr_sel_n(link.wr_sel_n), .addr(link.addr), .wd_rise(link.wd_rise),
        .wd_fall(link.wd_fall), .lane_rise_n(link.lane_rise_n), .lane_fall_n(link.lane_fall_n),
        .rq_valid(link.rq_valid), .rq_rise(link.rq_rise), .rq_fall(link.rq_fall));

    // 25 MHz clock
    initial
        forever #20 core_clk = ~core_clk;

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic timeout;
        fail_count++;
        $display("wrong value wait expected done seen timeout");
        results();
    endtask

    task automatic cmp_data(input string nm, input logic [71:0] exp, input logic [71:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cmp_flag(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // 144 random bits, so every lane and beat sees fresh data
    function automatic logic [143:0] rnd();
        rnd = '0;
        for (int i = 0; i < 5; i++)
            rnd = {rnd[111:0], $random(seed)};
    endfunction

    // expected word: a low lane takes the new nine bits
    function automatic logic [35:0] merge(input logic [35:0] old, nw, input logic [3:0] ln, input int n);
        merge = old;
        for (int l = 0; l < n; l++)
            if (!ln[l])
                merge[l*9 +: 9] = nw[l*9 +: 9];
    endfunction

    // controller write; the model follows at the edge that takes it
    task automatic c_write(input logic [7:0] a, input logic [143:0] d, input logic [15:0] ln);
        int i;
        @(negedge core_clk);
        wr_req = 1'b1;
        wr_addr = a;
        wr_data = d;
        wr_lanes_n = ln;
        #1;
        for (i = 0; i < 20 && wr_ready !== 1'b1; i++)
            #40;
        if (i == 20)
            timeout();
        for (int b = 0; b < 4; b++)
            mem[8'(a + b)] = merge(mem[8'(a + b)], d[b*36 +: 36], ln[b*4 +: 4], 4);
        @(negedge core_clk);
        wr_req = 1'b0;
        @(negedge core_clk);
        cmp_flag("wide write accepted", 1'b1, st[1]);
    endtask

    // controller read, both pairs compared against the model
    task automatic c_read(input logic [7:0] a);
        int i;
        int n;
        @(negedge core_clk);
        rd_req = 1'b1;
        rd_addr = a;
        #1;
        for (i = 0; i < 20 && rd_ready !== 1'b1; i++)
            #40;
        if (i == 20)
            timeout();
        @(negedge core_clk);
        rd_req = 1'b0;
        n = 0;
        for (i = 0; i < 12 && n < 2; i++)
        begin
            @(negedge core_clk);
            if (i == 0)
                cmp_flag("wide read accepted", 1'b1, st[0]);
            if (rd_valid === 1'b1)
            begin
                cmp_data("wide pair", {mem[8'(a + 2 * n + 1)], mem[8'(a + 2 * n)]}, rd_data);
                n++;
            end
        end
        if (n < 2)
            timeout();
    endtask

    // one cycle on the test link; unused data is random, never the last value
    task automatic s2(input logic r, w, input logic [7:0] a, input logic [35:0] d, input logic [3:0] l);
        @(negedge core_clk);
        link2.rd_sel_n = r;
        link2.wr_sel_n = w;
        link2.addr = a;
        link2.wd_rise = d[17:0];
        link2.wd_fall = d[35:18];
        link2.lane_rise_n = l[1:0];
        link2.lane_fall_n = l[3:2];
    endtask

    task automatic idle2;
        s2(1'b1, 1'b1, 8'(rnd()), 36'(rnd()), 4'hF);
    endtask

    // test-link write; b2b adds a second write on the next edge, which must be dropped
    task automatic l2_write(input logic [7:0] a, input logic [71:0] d, input logic [7:0] l, input logic b2b);
        s2(1'b1, 1'b0, a, 36'(rnd()), 4'hF);
        s2(1'b1, !b2b, 8'(a + 8), 36'(rnd()), 4'hF);
        cmp_flag("write accepted", 1'b1, st2[1]);
        s2(1'b1, 1'b1, 8'(rnd()), d[35:0], l[3:0]);
        cmp_flag("write discarded", b2b, st2[3]);
        s2(1'b1, 1'b1, 8'(rnd()), d[71:36], l[7:4]);
        cmp_flag("beat aborted", (&l[1:0]) | (&l[3:2]), st2[4]);
        s2(1'b1, 1'b1, 8'(rnd()), 36'(rnd()), {4{!b2b}});
        cmp_flag("beat aborted", (&l[5:4]) | (&l[7:6]), st2[4]);
        for (int b = 0; b < 4; b++)
            mem2[8'(a + b)] = 18'(merge({18'h0, mem2[8'(a + b)]}, {18'h0, d[b*18 +: 18]}, {2'b11, l[b*2 +: 2]}, 2));
        idle2();
    endtask

    // test-link read: m 1 adds a read on the next edge, m 2 pairs it with a write
    task automatic l2_read(input logic [7:0] a, input int m);
        int i;
        int n;
        if (m == 2)
            cmp_flag("idle before", 1'b1, st2[5]);
        s2(1'b0, m != 2, a, 36'(rnd()), 4'hF);
        s2(m != 1, 1'b1, 8'(a + 8), 36'(rnd()), 4'hF);
        cmp_flag("read accepted", 1'b1, st2[0]);
        cmp_flag("write taken", 1'b0, st2[1]);
        n = 0;
        for (i = 0; i < 12 && n < 2; i++)
        begin
            idle2();
            if (i == 0)
                cmp_flag("read discarded", m == 1, st2[2]);
            if (link2.rq_valid === 1'b1)
            begin
                cmp_data("narrow pair", {36'h0, mem2[8'(a + 2 * n + 1)], mem2[8'(a + 2 * n)]},
                    {36'h0, link2.rq_fall, link2.rq_rise});
                n++;
            end
        end
        if (n < 2)
            timeout();
        repeat (4)
        begin
            idle2();
            cmp_flag("extra pair", 1'b0, link2.rq_valid);
        end
    endtask

    // a hang anywhere ends the run as a failure
    initial
    begin
        repeat (20000) @(posedge core_clk);
        timeout();
    end

    // main sequence
    initial
    begin
        int i;
        idle2();
        repeat (15) @(negedge core_clk);
        rst = 1'b0;
        // fill both memories, back to back, so later reads have known answers
        for (int a = 0; a < 256; a += 4)
            c_write(8'(a), rnd(), 16'h0000);
        for (int a = 0; a < 256; a += 4)
            l2_write(8'(a), 72'(rnd()), 8'h00, 1'b0);
        $display("test preload done");
        // narrow lanes: lane 0, lane 1, both, none; then a dropped write and read, then read priority
        l2_write(8'h40, 72'(rnd()), 8'hC6, 1'b0);
        l2_read(8'h40, 0);
        l2_write(8'h50, 72'(rnd()), 8'h00, 1'b1);
        l2_read(8'h58, 0);
        l2_read(8'h50, 1);
        l2_read(8'h60, 2);
        $display("test narrow link done");
        // each single wide lane, then all and none, with an address wrap
        c_write(8'hFE, rnd(), 16'h7BDE);
        c_write(8'h10, rnd(), 16'hF0F0);
        repeat (6) @(negedge core_clk);
        c_read(8'hFE);
        c_read(8'h10);
        for (int k = 0; k < 30; k++)
        begin
            if ($random(seed) % 2 == 0)
            begin
                c_write(8'(rnd()), rnd(), 16'(rnd()));
                repeat (6) @(negedge core_clk);
            end
            else
                c_read(8'(rnd()));
        end
        // read then write on adjacent edges run side by side
        fork
            c_read(8'h80);
            begin
                // a whole edge later, so the write lands on the edge after the read
                @(negedge core_clk);
                c_write(8'h90, rnd(), 16'h0000);
            end
        join
        repeat (6) @(negedge core_clk);
        c_read(8'h90);
        $display("test wide link done");
        // stop right after a write: commands held off until the burst is gone
        c_write(8'h33, rnd(), 16'h0000);
        stop_req = 1'b1;
        rd_req = 1'b1;
        for (i = 0; i < 20 && stop_ok !== 1'b1; i++)
        begin
            @(negedge core_clk);
            cmp_flag("ready while stopping", 1'b0, rd_ready);
        end
        if (i == 20)
            timeout();
        cmp_flag("busy at stop", 1'b0, st[6]);
        cmp_flag("idle at stop", 1'b1, st[5]);
        cmp_flag("narrow busy", 1'b0, st2[6]);
        rd_req = 1'b0;
        stop_req = 1'b0;
        repeat (2) @(negedge core_clk);
        c_read(8'h33);
        $display("test stop done");
        results();
    end
endmodule
